// >>> sss_defs.svh
// Constants for the sleep-state sequencer: offsets, fields, resets, timing
// Notes on behaviour
// - S2 turns off resources referenced to S0 or S1; memory retention rail stays.
// - S3 turns off resources referenced to S0, S1 or S2.
// - S4 turns off resources referenced to S0 through S3.
// - S2 and S3 keep memory in self-refresh with its supply on.
// - S4 may drop memory power; contents are not kept.
// - In S2, S3, S4 processors stop and may lose power.
// - While asleep, devices whose resources are not all on go to off.
// - In S4 every device is forced to the off state.
// - Enabled wake in S2..S4 returns to working, processor starts at boot.
// - Some wake sources may work in S2 but not in S3.
// - Software sets the go bit after saving memory; S4 power-down starts.
// - Firmware hibernate path support implies direct software S4 path works.
// - Soft-off kind code differs from S4; boot firmware can tell them apart.
// - Leaving soft-off is a full cold boot with no saved context.
// - Wake result bit 0x1 means no power, 0x2 means thermal failure.
// - Wake result tracking is optional in hardware.
// - Supply state reached reports the sleep state the supply actually hit.
// - Writing one to the wake flag bit clears it.
`ifndef SSS_DEFS_SVH
`define SSS_DEFS_SVH
`define SSS_AW 8
`define SSS_A_CTRL 8'h00
`define SSS_A_STAT 8'h04
`define SSS_A_WEN 8'h08
`define SSS_A_WRES 8'h0C
`define SSS_A_KMAP 8'h10
`define SSS_A_DREF 8'h14
`define SSS_F_GO 3
`define SSS_F_FWP 4
`define SSS_F_WAK 0
`define SSS_F_PSS 4
`define SSS_F_LAST 8
`define SSS_F_COLD 11
`define SSS_F_FWU 12
`define SSS_WR_POWER 0
`define SSS_WR_THERM 1
`define SSS_K_S2 0
`define SSS_K_S3 4
`define SSS_K_S4 8
`define SSS_K_S5 12
`define SSS_KMAP_RST 16'h5432
`define SSS_S0 3'h0
`define SSS_S2 3'h2
`define SSS_S3 3'h3
`define SSS_S4 3'h4
`define SSS_S5 3'h5
`define SSS_NRES 4
`define SSS_NDEV 8
`define SSS_NWAKE 8
`define SSS_RES_ALL 4'hF
`define SSS_RES_S2 4'hC
`define SSS_RES_S3 4'h8
`define SSS_RES_S4 4'h0
`define SSS_OKAY 2'h0
`define SSS_SLVERR 2'h2
`define SSS_CLK_MHZ 40
`define SSS_STEP_NS 1000
`define SSS_STEP_CYC ((`SSS_STEP_NS * `SSS_CLK_MHZ + 999) / 1000)
`endif

// >>> sss_pkg.sv
// Types shared by the sleep-state sequencer modules
package sss_pkg;
    typedef logic [2:0] sss_snum_t;
    typedef enum {st_run, st_quiesce, st_power_down, st_asleep, st_power_up}
        sss_fsm_t;
endpackage

// >>> sss_tmr_if.sv
// Start and done handshake between sequencer and its step timer
`timescale 1ns/1ps
interface sss_tmr_if;
    logic start;
    logic done;
    modport ctl (output start, input done);
    modport tmr (input start, output done);
endinterface

// >>> sss_sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sss_sync2
#(
    parameter int W = 1
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// >>> sss_step_timer.sv
// Fixed step delay between power sequencing actions
`timescale 1ns/1ps
`include "sss_defs.svh"
module sss_step_timer
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    sss_tmr_if.tmr t
);
    logic [7:0] cnt;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt <= 8'h00;
            t.done <= 1'b0;
        end
        else
        begin
            t.done <= (cnt == 8'h01);
            if (t.start)
                cnt <= 8'(`SSS_STEP_CYC);
            else if (cnt != 8'h00)
                cnt <= cnt - 8'h01;
        end
    end
endmodule

// >>> sss_top.sv
// Sleep-state sequencer: register slave, power steps, wake handling
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "sss_defs.svh"
module sss_top
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register slave write channels
    input wire logic [`SSS_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Register slave read channels
    input wire logic [`SSS_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Pins from the platform
    input wire logic [`SSS_NWAKE-1:0] wake_pin,
    input wire logic supply_ok,
    input wire logic therm_trip,
    input wire sss_pkg::sss_snum_t supply_level,
    // Power controls
    output logic [`SSS_NRES-1:0] res_on,
    output logic dram_retain,
    output logic dram_pwr_on,
    output logic cpu_pwr_on,
    output logic cpu_run,
    output logic cpu_boot,
    output logic [`SSS_NDEV-1:0] dev_force_off,
    output logic cold_boot
);
    import sss_pkg::*;

    localparam int NW = `SSS_NWAKE + 5;

    logic [NW-1:0] pin_raw;
    logic [NW-1:0] pin_s;
    logic [`SSS_NWAKE-1:0] wake_s;
    logic supply_ok_s;
    logic therm_s;
    sss_snum_t level_s;
    logic [`SSS_AW-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_wr;
    logic wr_ctrl;
    logic go_req;
    logic [15:0] kmap;
    logic [15:0] wen;
    logic [15:0] dref;
    logic [2:0] kind;
    logic fw_path;
    logic fw_used;
    logic wake_seen;
    logic [1:0] wres;
    logic [1:0] wres_set;
    sss_snum_t supply_state_reached;
    sss_snum_t last_state;
    sss_snum_t target;
    sss_snum_t tgt;
    logic tgt_ok;
    sss_fsm_t fsm;
    logic tstart;
    logic tmr_done;
    logic [`SSS_NWAKE-1:0] wmask;
    logic wake_hit;
    logic wake_ok;
    logic wake_set;
    logic sleeping;
    logic deep;
    logic [31:0] rd_word;
    logic rd_hit;

    // Supply level is a slow status bus; a torn sample stays in the sleep record until the next power-down
    assign pin_raw = {supply_level, therm_trip, supply_ok, wake_pin};

    sss_sync2 #(.W(NW)) u_sync
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(pin_raw),
        .q(pin_s)
    );

    assign wake_s = pin_s[`SSS_NWAKE-1:0];
    assign supply_ok_s = pin_s[`SSS_NWAKE];
    assign therm_s = pin_s[`SSS_NWAKE+1];
    assign level_s = pin_s[NW-1 -: 3];

    sss_tmr_if tif();

    sss_step_timer u_tmr
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .t(tif)
    );

    assign tif.start = tstart;
    assign tmr_done = tif.done;

    function automatic logic addr_hit(input logic [`SSS_AW-1:0] a);
        return a == `SSS_A_CTRL || a == `SSS_A_STAT || a == `SSS_A_WEN ||
            a == `SSS_A_WRES || a == `SSS_A_KMAP || a == `SSS_A_DREF;
    endfunction

    function automatic logic [15:0] upd16(input logic [15:0] old);
        return {w_strb_q[1] ? w_data_q[15:8] : old[15:8],
            w_strb_q[0] ? w_data_q[7:0] : old[7:0]};
    endfunction

    // Write channels: address and data are taken in either order
    assign do_wr = !awready && !wready && !bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `SSS_OKAY;
            aw_addr_q <= '0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awready <= 1'b0;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                wready <= 1'b0;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_wr)
            begin
                bvalid <= 1'b1;
                bresp <= addr_hit(aw_addr_q) ? `SSS_OKAY : `SSS_SLVERR;
            end
            else if (bvalid && bready)
            begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    assign wr_ctrl = do_wr && aw_addr_q == `SSS_A_CTRL && w_strb_q[0];
    assign go_req = wr_ctrl && w_data_q[`SSS_F_GO];

    // Setup registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            kmap <= `SSS_KMAP_RST;
            wen <= 16'h0000;
            dref <= 16'h0000;
            kind <= `SSS_S0;
            fw_path <= 1'b0;
        end
        else if (do_wr)
        begin
            if (wr_ctrl)
            begin
                kind <= w_data_q[2:0];
                fw_path <= w_data_q[`SSS_F_FWP];
            end
            if (aw_addr_q == `SSS_A_KMAP)
                kmap <= upd16(kmap);
            if (aw_addr_q == `SSS_A_WEN)
                wen <= upd16(wen);
            if (aw_addr_q == `SSS_A_DREF)
                dref <= upd16(dref);
        end
    end

    // Soft-off is matched first so a clash with the S4 code never hides it
    always_comb
    begin
        tgt_ok = 1'b1;
        tgt = `SSS_S2;
        if (w_data_q[2:0] == kmap[`SSS_K_S5 +: 3])
            tgt = `SSS_S5;
        else if (w_data_q[2:0] == kmap[`SSS_K_S4 +: 3])
            tgt = `SSS_S4;
        else if (w_data_q[2:0] == kmap[`SSS_K_S3 +: 3])
            tgt = `SSS_S3;
        else if (w_data_q[2:0] != kmap[`SSS_K_S2 +: 3])
            tgt_ok = 1'b0;
    end

    // S2 honours every enabled source; deeper states only the survivors
    assign wmask = (target == `SSS_S2) ? wen[7:0] : wen[7:0] & wen[15:8];
    assign wake_hit = fsm == st_asleep && |(wake_s & wmask);
    assign wake_ok = wake_hit && supply_ok_s && !therm_s;
    assign wake_set = fsm == st_power_up && tmr_done;
    assign sleeping = fsm == st_power_down || fsm == st_asleep;
    assign deep = target == `SSS_S4 || target == `SSS_S5;

    // Power sequencing
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fsm <= st_run;
            target <= `SSS_S0;
            tstart <= 1'b0;
            res_on <= `SSS_RES_ALL;
            dram_retain <= 1'b0;
            dram_pwr_on <= 1'b1;
            cpu_pwr_on <= 1'b1;
            cpu_run <= 1'b1;
            cpu_boot <= 1'b0;
        end
        else
        begin
            tstart <= 1'b0;
            cpu_boot <= 1'b0;
            case (fsm)
                st_run:
                    if (go_req && tgt_ok)
                    begin
                        target <= tgt;
                        cpu_run <= 1'b0;
                        tstart <= 1'b1;
                        fsm <= st_quiesce;
                    end
                st_quiesce:
                    if (tmr_done)
                    begin
                        case (target)
                            `SSS_S2: res_on <= `SSS_RES_S2;
                            `SSS_S3: res_on <= `SSS_RES_S3;
                            default: res_on <= `SSS_RES_S4;
                        endcase
                        dram_retain <= !deep;
                        dram_pwr_on <= !deep;
                        cpu_pwr_on <= 1'b0;
                        tstart <= 1'b1;
                        fsm <= st_power_down;
                    end
                st_power_down:
                    if (tmr_done)
                        fsm <= st_asleep;
                st_asleep:
                    if (wake_ok)
                    begin
                        res_on <= `SSS_RES_ALL;
                        dram_pwr_on <= 1'b1;
                        cpu_pwr_on <= 1'b1;
                        tstart <= 1'b1;
                        fsm <= st_power_up;
                    end
                st_power_up:
                    if (tmr_done)
                    begin
                        dram_retain <= 1'b0;
                        cpu_run <= 1'b1;
                        cpu_boot <= 1'b1;
                        fsm <= st_run;
                    end
                default:
                    fsm <= st_run;
            endcase
        end
    end

    // Device forcing follows the resource state one cycle later
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            dev_force_off <= '0;
        else
            for (int i = 0; i < `SSS_NDEV; i++)
                dev_force_off[i] <= sleeping &&
                    (deep || !res_on[dref[2*i +: 2]]);
    end

    // Status flags; a set in the clearing cycle wins
    assign wres_set[`SSS_WR_POWER] = wake_hit && !supply_ok_s;
    assign wres_set[`SSS_WR_THERM] = wake_hit && therm_s;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wake_seen <= 1'b0;
            wres <= 2'h0;
        end
        else
        begin
            wake_seen <= wake_set || (wake_seen && !(do_wr &&
                aw_addr_q == `SSS_A_STAT && w_strb_q[0] &&
                w_data_q[`SSS_F_WAK]));
            wres <= wres_set | (wres & ~((do_wr && aw_addr_q == `SSS_A_WRES
                && w_strb_q[0]) ? w_data_q[1:0] : 2'h0));
        end
    end

    // Sleep record for software and boot firmware
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            supply_state_reached <= `SSS_S0;
            last_state <= `SSS_S0;
            fw_used <= 1'b0;
            cold_boot <= 1'b0;
        end
        else
        begin
            if (fsm == st_power_down && tmr_done)
            begin
                supply_state_reached <= level_s;
                last_state <= target;
                fw_used <= fw_path && target == `SSS_S4;
            end
            if (wake_set)
                cold_boot <= target == `SSS_S5;
        end
    end

    // Read channel
    always_comb
    begin
        rd_word = 32'h00000000;
        rd_hit = addr_hit(araddr);
        case (araddr)
            `SSS_A_CTRL:
            begin
                rd_word[2:0] = kind;
                rd_word[`SSS_F_FWP] = fw_path;
            end
            `SSS_A_STAT:
            begin
                rd_word[`SSS_F_WAK] = wake_seen;
                rd_word[`SSS_F_PSS +: 3] = supply_state_reached;
                rd_word[`SSS_F_LAST +: 3] = last_state;
                rd_word[`SSS_F_COLD] = cold_boot;
                rd_word[`SSS_F_FWU] = fw_used;
            end
            `SSS_A_WEN: rd_word[15:0] = wen;
            `SSS_A_WRES: rd_word[1:0] = wres;
            `SSS_A_KMAP: rd_word[15:0] = kmap;
            `SSS_A_DREF: rd_word[15:0] = dref;
            default: rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `SSS_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_hit ? `SSS_OKAY : `SSS_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_s2_res_off: assert property (fsm == st_asleep &&
        target == `SSS_S2 |-> res_on == `SSS_RES_S2)
        else $error("S2 resources wrong");
    chk_s3_res_off: assert property (fsm == st_asleep &&
        target == `SSS_S3 |-> res_on == `SSS_RES_S3)
        else $error("S3 resources wrong");
    chk_deep_res_off: assert property (fsm == st_asleep &&
        deep |-> res_on == `SSS_RES_S4 && !dram_pwr_on)
        else $error("S4 resources wrong");
    chk_dram_kept: assert property (sleeping && !deep
        |-> dram_retain && dram_pwr_on)
        else $error("Memory not retained");
    chk_cpu_halted: assert property (sleeping
        |-> !cpu_run && !cpu_pwr_on)
        else $error("Processor active while asleep");
    chk_deep_dev_off: assert property (fsm == st_asleep && deep
        |=> dev_force_off == '1)
        else $error("Device not forced off");
    chk_wake_boot: assert property (wake_ok
        |=> fsm == st_power_up ##[1:60] cpu_boot)
        else $error("Wake did not boot processor");
    chk_go_starts: assert property (fsm == st_run && go_req &&
        tgt_ok |=> fsm == st_quiesce && !cpu_run && target == $past(tgt))
        else $error("Go bit ignored");
    chk_wake_flag: assert property (cpu_boot |-> wake_seen &&
        $past(fsm) == st_power_up)
        else $error("Wake flag not set");
    chk_wres_power: assert property (wres_set[`SSS_WR_POWER]
        |=> wres[`SSS_WR_POWER] && fsm == st_asleep)
        else $error("Power failure not recorded");
    chk_cold_boot: assert property (cpu_boot
        |-> cold_boot == (target == `SSS_S5))
        else $error("Cold boot flag wrong");

    cov_s2_trip: cover property (cpu_boot && target == `SSS_S2);
    cov_s4_trip: cover property (cpu_boot && target == `SSS_S4);
    cov_soft_off: cover property (cpu_boot && cold_boot);
    cov_wake_fail: cover property (wres_set != 2'h0);
endmodule

// >>> sss_top_bench.sv
// Self-checking bench for the sleep-state sequencer over its register bus
`timescale 1ns/1ps
`include "sss_defs.svh"
module sss_top_bench;
    import sss_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [`SSS_AW-1:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [`SSS_AW-1:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic [`SSS_NWAKE-1:0] wake_pin = 8'h00;
    logic supply_ok = 1'b1;
    logic therm_trip = 1'b0;
    sss_snum_t supply_level = 3'h0;
    logic [`SSS_NRES-1:0] res_on;
    logic dram_retain;
    logic dram_pwr_on;
    logic cpu_pwr_on;
    logic cpu_run;
    logic cpu_boot;
    logic [`SSS_NDEV-1:0] dev_force_off;
    logic cold_boot;
    int bad_count = 0;
    int checked = 0;
    always #12.5 aclk = ~aclk;
    sss_top DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .wake_pin(wake_pin), .supply_ok(supply_ok),
        .therm_trip(therm_trip), .supply_level(supply_level),
        .res_on(res_on), .dram_retain(dram_retain),
        .dram_pwr_on(dram_pwr_on), .cpu_pwr_on(cpu_pwr_on),
        .cpu_run(cpu_run), .cpu_boot(cpu_boot),
        .dev_force_off(dev_force_off), .cold_boot(cold_boot));
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic hang(input int n, input int lim);
        if (n >= lim)
        begin
            bad_count++;
            $display("[FAIL] t=%0t wait ran out got=%h exp=%h", $time, n,
                lim);
            summarize();
        end
    endtask
    // Address and data are offered together; each drops once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1 && n < 200);
        bready <= 1'b0;
        hang(n, 200);
        cmp(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic [31:0] m, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1 && n < 200);
        rready <= 1'b0;
        hang(n, 200);
        cmp(rdata & m, exp);
        cmp(32'(rresp), 32'(er));
    endtask
    // Device 7 needs group 3, which only the deep states switch off
    task automatic sleep(input logic [2:0] k, input logic fw);
        int n;
        n = 0;
        wr(`SSS_A_CTRL, {27'h0, fw, 1'b1, k}, `SSS_OKAY);
        while (cpu_pwr_on !== 1'b0 && n < 300)
        begin
            @(posedge aclk);
            n++;
        end
        hang(n, 300);
        // Device forcing trails the power step by one cycle
        @(posedge aclk);
    endtask
    task automatic wake();
        int n;
        n = 0;
        @(posedge aclk);
        wake_pin[0] <= 1'b1;
        while (cpu_boot !== 1'b1 && n < 300)
        begin
            @(posedge aclk);
            n++;
        end
        hang(n, 300);
        wake_pin[0] <= 1'b0;
        cmp(32'(cpu_run), 32'h1);
        cmp(32'(res_on), 32'(`SSS_RES_ALL));
        cmp({cpu_pwr_on, dram_pwr_on, dram_retain}, 32'h6);
        cmp(32'(dev_force_off), 32'h0);
        @(posedge aclk);
        cmp(32'(cpu_boot), 32'h0);
    endtask
    task automatic pulse_fail();
        @(posedge aclk);
        wake_pin[0] <= 1'b1;
        repeat (6) @(posedge aclk);
        wake_pin[0] <= 1'b0;
        repeat (60) @(posedge aclk);
        cmp(32'(cpu_run), 32'h0);
    endtask
    logic [3:0] masks [4] = '{`SSS_RES_S2, `SSS_RES_S3, `SSS_RES_S4, 4'h0};
    logic [2:0] st;
    logic [2:0] kind;
    logic [2:0] lvl;
    logic fw;
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cmp({res_on, 3'h0, cpu_run, 3'h0, dram_pwr_on}, 32'hF11);
        cmp({dev_force_off, 3'h0, cold_boot, 3'h0, cpu_pwr_on}, 32'h001);
        rd(`SSS_A_KMAP, 32'h5432, 32'h7777, `SSS_OKAY);
        wr(8'h40, 32'hFFFF_FFFF, `SSS_SLVERR);
        rd(8'h40, 32'h0, 32'hFFFF_FFFF, `SSS_SLVERR);
        wr(`SSS_A_DREF, 32'hC000, `SSS_OKAY);
        wr(`SSS_A_WEN, 32'h00FF, `SSS_OKAY);
        // Kind 7 is in no slot of the map, so the go bit must do nothing
        wr(`SSS_A_CTRL, 32'h0000_000F, `SSS_OKAY);
        repeat (100) @(posedge aclk);
        cmp(32'(cpu_run), 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            st = 3'(i + 2);
            kind = 3'(`SSS_KMAP_RST >> (4 * i));
            fw = (i == 2);
            // Supply stops one state shallow on the S3 trip
            lvl = (i == 1) ? 3'h2 : st;
            supply_level <= lvl;
            if (i == 3)
                wr(`SSS_A_WEN, 32'h0, `SSS_OKAY);
            sleep(kind, fw);
            cmp(32'(res_on), 32'(masks[i]));
            cmp({cpu_run, cpu_pwr_on}, 32'h0);
            cmp(32'(dev_force_off),
                (i < 2) ? 32'h7F : 32'hFF);
            if (i < 2)
                cmp({dram_retain, dram_pwr_on}, 32'h3);
            else
                cmp({dram_retain, dram_pwr_on}, 32'h0);
            // A second go during the power-down step must not disturb the state
            wr(`SSS_A_CTRL, {27'h0, fw, 4'hA}, `SSS_OKAY);
            repeat (100) @(posedge aclk);
            cmp(32'(res_on), 32'(masks[i]));
            rd(`SSS_A_CTRL, {27'h0, fw, 4'h2}, 32'h1F, `SSS_OKAY);
            if (i == 0)
            begin
                supply_ok <= 1'b0;
                pulse_fail();
                rd(`SSS_A_WRES, 32'h1, 32'h3, `SSS_OKAY);
                supply_ok <= 1'b1;
                therm_trip <= 1'b1;
                pulse_fail();
                rd(`SSS_A_WRES, 32'h3, 32'h3, `SSS_OKAY);
                therm_trip <= 1'b0;
                wr(`SSS_A_WRES, 32'h3, `SSS_OKAY);
                rd(`SSS_A_WRES, 32'h0, 32'h3, `SSS_OKAY);
            end
            if (i == 1)
            begin
                pulse_fail();
                wr(`SSS_A_WEN, 32'hFFFF, `SSS_OKAY);
            end
            if (i == 3)
                wr(`SSS_A_WEN, 32'hFFFF, `SSS_OKAY);
            wake();
            cmp(32'(cold_boot), 32'(i == 3));
            rd(`SSS_A_STAT, {19'h0, fw, 1'(i == 3), st, 1'b0, lvl,
               4'h1}, 32'h1F71, `SSS_OKAY);
            wr(`SSS_A_STAT, 32'h1, `SSS_OKAY);
            rd(`SSS_A_STAT, 32'h0, 32'h1, `SSS_OKAY);
        end
        summarize();
    end
endmodule
